// ===== inc/dma_status_pkg.sv
package dma_status_pkg;

   // -------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------
   localparam int          CHANNELS     = 16;
   localparam logic [31:0] STATUS_BASE  = 32'hFF900014;
   localparam logic [31:0] CHAN_STRIDE  = 32'h00000020;
   localparam int          STRIDE_SHIFT = 5;

   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int PEND_MSB     = 31;  // normal, error, not ready, abort, early
   localparam int PEND_LSB     = 27;
   localparam int EN_MSB       = 24;  // early, normal, error, not ready, abort
   localparam int EN_LSB       = 20;
   localparam int FLAGS_MSB    = 19;  // wrap, irq on done, last, full
   localparam int FLAGS_LSB    = 16;
   localparam int COUNT_MSB    = 14;
   localparam int COUNT_LSB    = 0;
   localparam int COUNT_W      = 15;
   localparam int FLAGS_W      = 4;
   localparam int COND_W       = 5;

   // Index of each condition inside the pending field
   localparam int P_NORMAL     = 4;
   localparam int P_ERROR      = 3;
   localparam int P_NRDY       = 2;
   localparam int P_ABORT      = 1;
   localparam int P_EARLY      = 0;
   // Index of each condition inside the enable field
   localparam int E_EARLY      = 4;
   localparam int E_NORMAL     = 3;
   localparam int E_ERROR      = 2;
   localparam int E_NRDY       = 1;
   localparam int E_ABORT      = 0;
   // Index of irq on done inside the descriptor flags
   localparam int F_IRQ_DONE   = 2;

   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic [4:0]  PEND_RESET   = 5'h00;
   localparam logic [4:0]  EN_RESET     = 5'h00;
   localparam logic [31:0] RDATA_RESET  = 32'h00000000;
   localparam logic [14:0] COUNT_ZERO   = 15'h0000;

   // -------------------------------------------------------------
   // Channel sequencing states
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      CH_RUN,
      CH_ERR_STALL,
      CH_NRDY_STALL,
      CH_ABORT_STALL
   } chan_state_t;

endpackage

// ===== rtl/dma_channel_status_irq.sv
`timescale 1ns/10ps

// What this block does
// - Sixteen per-channel status/enable registers, 0x20 apart from the first address.
// - Channel interrupt raised when a pending flag and its enable are both set.
// - Writing one to a pending bit clears it; zero leaves it.
// - Normal pending bit 31 set on normal close if enabled or descriptor asks.
// - Normal close: byte count reaches zero, or peripheral signals completion.
// - Error pending bit 30 set on bad descriptor or data buffer pointer.
// - Error stalls channel; after clear it resumes same descriptor where stopped.
// - Abort during a stall abandons the descriptor and moves to the next.
// - Not-ready pending bit 29 set when descriptor full bit is wrong.
// - Not-ready stalls channel; after clear it refetches the same descriptor.
// - Abort pending bit 28 set on seeing abort request; channel stalls meanwhile.
// - Clearing abort pending advances the channel to the next descriptor.
// - Fly-by read early end sets early pending bit 27, then advances.
// - Early pending always sets normal pending as well.
// - Bit 20 is the read/write abort interrupt enable.
// - Low fifteen bits read back the remaining byte count, read only.
module dma_channel_status_irq
   import dma_status_pkg::*;
#(
   parameter int NUM_CH = CHANNELS
) (
   // Clock and reset
   input  wire logic                      i_clock,
   input  wire logic                      i_arst_n,
   // Register port
   input  wire logic [31:0]               i_addr,
   input  wire logic [31:0]               i_wdata,
   input  wire logic                      i_wr,
   input  wire logic                      i_rd,
   output logic      [31:0]               o_rdata,
   // Events from the channel engines, one bit per channel
   input  wire logic [NUM_CH-1:0]         i_desc_end,
   input  wire logic [NUM_CH-1:0]         i_periph_done,
   input  wire logic [NUM_CH-1:0]         i_bad_desc_ptr,
   input  wire logic [NUM_CH-1:0]         i_bad_buf_ptr,
   input  wire logic [NUM_CH-1:0]         i_full_wrong,
   input  wire logic [NUM_CH-1:0]         i_chan_abort_request,
   input  wire logic [NUM_CH-1:0]         i_flyby_read,
   input  wire logic [NUM_CH-1:0]         i_periph_eot,
   // Current descriptor state, per channel
   input  wire logic [NUM_CH*FLAGS_W-1:0] i_desc_flags,
   input  wire logic [NUM_CH*COUNT_W-1:0] i_remaining_byte_count,
   // Sequencing commands to the channel engines
   output logic      [NUM_CH-1:0]         o_stall,
   output logic      [NUM_CH-1:0]         o_advance,
   output logic      [NUM_CH-1:0]         o_retry,
   output logic      [NUM_CH-1:0]         o_resume,
   // Interrupts
   output logic      [NUM_CH-1:0]         o_chan_irq,
   output logic                           o_irq
);

   // -------------------------------------------------------------
   // Decode helpers
   // -------------------------------------------------------------

   // True when the address hits the register of channel ch
   function automatic logic addr_hit(input logic [31:0] addr, input int ch);
      logic [31:0] offs;
      offs     = addr - STATUS_BASE;
      addr_hit = (offs[STRIDE_SHIFT-1:0] == '0) &&
                 (offs[31:STRIDE_SHIFT] == 27'(ch));
   endfunction

   // Reorder the enable field into the pending field layout
   function automatic logic [COND_W-1:0] en_to_pend(input logic [COND_W-1:0] en);
      logic [COND_W-1:0] r;
      r          = '0;
      r[P_NORMAL] = en[E_NORMAL];
      r[P_ERROR]  = en[E_ERROR];
      r[P_NRDY]   = en[E_NRDY];
      r[P_ABORT]  = en[E_ABORT];
      r[P_EARLY]  = en[E_EARLY];
      en_to_pend = r;
   endfunction

   // -------------------------------------------------------------
   // Per-channel state
   // -------------------------------------------------------------
   logic [COND_W-1:0]  pend_reg  [NUM_CH];
   logic [COND_W-1:0]  en_reg    [NUM_CH];
   logic [NUM_CH-1:0]  chan_irq;
   logic [NUM_CH-1:0]  chan_irq_next;

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : gen_ch
         chan_state_t        state_reg;
         chan_state_t        state_next;
         logic [COND_W-1:0]  pend_next;
         logic [COND_W-1:0]  en_next;
         logic [COND_W-1:0]  set_v;
         logic [COND_W-1:0]  clr_v;
         logic               adv_reg;
         logic               adv_next;
         logic               retry_reg;
         logic               retry_next;
         logic               resume_reg;
         logic               resume_next;
         logic               irq_reg;
         logic               irq_next;
         logic               stall_reg;
         logic               stall_next;
         logic               wr_hit;
         logic               normal_close;
         logic               early_end;
         logic [COUNT_W-1:0] count;
         logic [FLAGS_W-1:0] flags;

         // ----------------------------------------------------
         // Channel inputs
         // ----------------------------------------------------

         // Slices of the packed per-channel buses
         assign count = i_remaining_byte_count[g*COUNT_W +: COUNT_W];
         assign flags = i_desc_flags[g*FLAGS_W +: FLAGS_W];
         assign wr_hit = i_wr && addr_hit(i_addr, g);

         // Completion decode; an early end replaces a normal close
         assign early_end    = i_flyby_read[g] && i_periph_eot[g];
         assign normal_close = ((i_desc_end[g] && (count == COUNT_ZERO)) ||
                                i_periph_done[g]) && !early_end;

         // ----------------------------------------------------
         // Sequencing state machine
         // ----------------------------------------------------

         // Next sequencing state, flag sets and engine commands
         always_comb begin
            state_next  = state_reg;
            set_v       = '0;
            adv_next    = 1'b0;
            retry_next  = 1'b0;
            resume_next = 1'b0;
            unique case (state_reg)
               CH_RUN: begin
                  // Abort wins over other events seen in the same cycle
                  if (i_chan_abort_request[g]) begin
                     set_v[P_ABORT] = 1'b1;
                     state_next     = CH_ABORT_STALL;
                  end else if (i_bad_desc_ptr[g] || i_bad_buf_ptr[g]) begin
                     set_v[P_ERROR] = 1'b1;
                     state_next     = CH_ERR_STALL;
                  end else if (i_full_wrong[g]) begin
                     set_v[P_NRDY] = 1'b1;
                     state_next    = CH_NRDY_STALL;
                  end else if (early_end) begin
                     set_v[P_EARLY]  = 1'b1;
                     set_v[P_NORMAL] = 1'b1;
                     adv_next        = 1'b1;
                  end else if (normal_close) begin
                     set_v[P_NORMAL] = en_reg[g][E_NORMAL] || flags[F_IRQ_DONE];
                     adv_next        = 1'b1;
                  end
               end
               CH_ERR_STALL: begin
                  if (i_chan_abort_request[g]) begin
                     set_v[P_ABORT] = 1'b1;
                     state_next     = CH_ABORT_STALL;
                  end else if (!pend_reg[g][P_ERROR]) begin
                     resume_next = 1'b1;
                     state_next  = CH_RUN;
                  end
               end
               CH_NRDY_STALL: begin
                  if (i_chan_abort_request[g]) begin
                     set_v[P_ABORT] = 1'b1;
                     state_next     = CH_ABORT_STALL;
                  end else if (!pend_reg[g][P_NRDY]) begin
                     retry_next = 1'b1;
                     state_next = CH_RUN;
                  end
               end
               CH_ABORT_STALL: begin
                  // A request still high after this re-aborts the next descriptor
                  if (!pend_reg[g][P_ABORT]) begin
                     adv_next   = 1'b1;
                     state_next = CH_RUN;
                  end
               end
            endcase
            // Registered copy keeps the stall pin free of decode glitches
            stall_next = (state_next != CH_RUN);
         end

         // ----------------------------------------------------
         // Pending flags and enables
         // ----------------------------------------------------

         // Pending and enable updates; a set in the clearing cycle wins
         always_comb begin
            clr_v     = wr_hit ? i_wdata[PEND_MSB:PEND_LSB] : '0;
            pend_next = (pend_reg[g] & ~clr_v) | set_v;
            en_next   = wr_hit ? i_wdata[EN_MSB:EN_LSB] : en_reg[g];
            irq_next  = |(pend_next & en_to_pend(en_next));
         end

         // ----------------------------------------------------
         // Channel registers
         // ----------------------------------------------------

         // Registers of the channel
         always_ff @(posedge i_clock or negedge i_arst_n) begin
            if (!i_arst_n) begin
               state_reg   <= CH_RUN;
               pend_reg[g] <= PEND_RESET;
               en_reg[g]   <= EN_RESET;
               adv_reg     <= 1'b0;
               retry_reg   <= 1'b0;
               resume_reg  <= 1'b0;
               irq_reg     <= 1'b0;
               stall_reg   <= 1'b0;
            end else begin
               state_reg   <= state_next;
               pend_reg[g] <= pend_next;
               en_reg[g]   <= en_next;
               adv_reg     <= adv_next;
               retry_reg   <= retry_next;
               resume_reg  <= resume_next;
               irq_reg     <= irq_next;
               stall_reg   <= stall_next;
            end
         end

         // ----------------------------------------------------
         // Channel outputs
         // ----------------------------------------------------

         // All commands leave straight from flip-flops
         assign o_stall[g]       = stall_reg;
         assign o_advance[g]     = adv_reg;
         assign o_retry[g]       = retry_reg;
         assign o_resume[g]      = resume_reg;
         assign chan_irq[g]      = irq_reg;
         assign chan_irq_next[g] = irq_next;
      end
   endgenerate

   assign o_chan_irq = chan_irq;

   // -------------------------------------------------------------
   // Combined interrupt line
   // -------------------------------------------------------------
   logic irq_reg;
   logic irq_next;

   // Built from the next channel values so it rises with the channel lines;
   // a generate scope cannot be indexed by a loop variable, hence the vector
   always_comb begin
      irq_next = |chan_irq_next;
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= irq_next;
      end
   end

   assign o_irq = irq_reg;

   // -------------------------------------------------------------
   // Read path
   // -------------------------------------------------------------
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;

   // Unmapped addresses and idle cycles return zero; reserved bits are zero
   always_comb begin
      rdata_next = RDATA_RESET;
      if (i_rd) begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (addr_hit(i_addr, c)) begin
               rdata_next[PEND_MSB:PEND_LSB]   = pend_reg[c];
               rdata_next[EN_MSB:EN_LSB]       = en_reg[c];
               rdata_next[FLAGS_MSB:FLAGS_LSB] = i_desc_flags[c*FLAGS_W +: FLAGS_W];
               rdata_next[COUNT_MSB:COUNT_LSB] = i_remaining_byte_count[c*COUNT_W +: COUNT_W];
            end
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_reg <= RDATA_RESET;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign o_rdata = rdata_reg;

endmodule

// ===== dv/dma_channel_status_irq_asserts.sv
`timescale 1ns/10ps

// ------------------------------------------------
// Port checker, watching channel 0 and the irqs
// ------------------------------------------------
module dma_channel_status_irq_checker
   import dma_status_pkg::*;
#(
   parameter int NUM_CH = CHANNELS
) (
   // Clock and reset
   input wire logic                      i_clock,
   input wire logic                      i_arst_n,
   // Register port
   input wire logic [31:0]               i_addr,
   input wire logic [31:0]               i_wdata,
   input wire logic                      i_wr,
   input wire logic                      i_rd,
   input wire logic [31:0]               o_rdata,
   // Channel events and state
   input wire logic [NUM_CH-1:0]         i_desc_end,
   input wire logic [NUM_CH-1:0]         i_periph_done,
   input wire logic [NUM_CH-1:0]         i_bad_desc_ptr,
   input wire logic [NUM_CH-1:0]         i_bad_buf_ptr,
   input wire logic [NUM_CH-1:0]         i_full_wrong,
   input wire logic [NUM_CH-1:0]         i_chan_abort_request,
   input wire logic [NUM_CH-1:0]         i_flyby_read,
   input wire logic [NUM_CH-1:0]         i_periph_eot,
   input wire logic [NUM_CH*COUNT_W-1:0] i_remaining_byte_count,
   // Sequencing and interrupts
   input wire logic [NUM_CH-1:0]         o_stall,
   input wire logic [NUM_CH-1:0]         o_advance,
   input wire logic [NUM_CH-1:0]         o_retry,
   input wire logic [NUM_CH-1:0]         o_resume,
   input wire logic [NUM_CH-1:0]         o_chan_irq,
   input wire logic                      o_irq
);
   logic quiet0;
   logic idle0;

   // No higher-priority event on channel 0
   assign quiet0 = !(i_chan_abort_request[0] | i_bad_desc_ptr[0] | i_bad_buf_ptr[0] | i_full_wrong[0]);
   assign idle0  = quiet0 && !(i_desc_end[0] | i_periph_done[0] | i_periph_eot[0]);

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_arst_n);

   property p_irq_or; o_irq == (|o_chan_irq); endproperty
   a_irq_or: assert property (p_irq_or) else $error("summary irq differs from channel irqs");
   property p_err; !o_stall[0] && !i_chan_abort_request[0] && i_bad_buf_ptr[0] |=> o_stall[0]; endproperty
   a_err: assert property (p_err) else $error("bad pointer did not stall");
   // Past write excluded: the stall drops two cycles after the clear
   property p_hold; o_stall[0] && !i_wr && !$past(i_wr) |=> o_stall[0]; endproperty
   a_hold: assert property (p_hold) else $error("stall dropped without a clear");
   property p_fell; $fell(o_stall[0]) |-> o_advance[0] || o_retry[0] || o_resume[0]; endproperty
   a_fell: assert property (p_fell) else $error("stall left without a command");
   property p_abort; !o_stall[0] && i_chan_abort_request[0] |=> o_stall[0] && !o_advance[0]; endproperty
   a_abort: assert property (p_abort) else $error("abort request did not stall");
   property p_early; !o_stall[0] && quiet0 && i_flyby_read[0] && i_periph_eot[0] |=> o_advance[0]; endproperty
   a_early: assert property (p_early) else $error("early end did not advance");
   property p_done; !o_stall[0] && quiet0 && !i_periph_eot[0] && i_periph_done[0] |=> o_advance[0]; endproperty
   a_done: assert property (p_done) else $error("peripheral done did not advance");
   property p_clr; i_wr && i_addr == STATUS_BASE && i_wdata[31:27] == 5'h1F && idle0 |=> !o_chan_irq[0]; endproperty
   a_clr: assert property (p_clr) else $error("irq stayed after clearing all flags");
   // Count is sampled in the strobe cycle, so compare against its past value
   property p_cnt; i_rd && i_addr == STATUS_BASE |=>
      o_rdata[14:0] == $past(i_remaining_byte_count[14:0]); endproperty
   a_cnt: assert property (p_cnt) else $error("count readback wrong");
   property p_hole; i_rd && i_addr == STATUS_BASE + 32'h4 |=> o_rdata == 32'h0; endproperty
   a_hole: assert property (p_hole) else $error("unmapped read not zero");
endmodule

bind dma_channel_status_irq dma_channel_status_irq_checker #(.NUM_CH(NUM_CH)) chk_i (.i_clock, .i_arst_n,
   .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_desc_end, .i_periph_done, .i_bad_desc_ptr, .i_bad_buf_ptr,
   .i_full_wrong, .i_chan_abort_request, .i_flyby_read, .i_periph_eot, .i_remaining_byte_count, .o_stall,
   .o_advance, .o_retry, .o_resume, .o_chan_irq, .o_irq);

// ===== dv/dma_channel_status_irq_tb.sv
`timescale 1ns/10ps

// ------------------------------------------------
// Register and event sequences
// ------------------------------------------------
module dma_channel_status_irq_tb
   import dma_status_pkg::*;
;
   logic         i_clock = 1'b0;
   logic         i_arst_n = 1'b0;
   logic [31:0]  i_addr = 32'h0, i_wdata = 32'h0, o_rdata;
   logic         i_wr = 1'b0, i_rd = 1'b0, o_irq;
   logic [15:0]  i_desc_end = '0, i_periph_done = '0, i_bad_desc_ptr = '0, i_bad_buf_ptr = '0;
   logic [15:0]  i_full_wrong = '0, i_chan_abort_request = '0, i_periph_eot = '0;
   logic [15:0]  i_flyby_read = 16'h0001;
   logic [15:0]  o_stall, o_advance, o_retry, o_resume, o_chan_irq;
   logic [63:0]  i_desc_flags = {4'hA, 60'h0};
   logic [239:0] i_remaining_byte_count = {15'h1234, 225'h0};
   int           n_fail = 0, compares = 0, cycles = 0;

   dma_channel_status_irq dut (.i_clock, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_desc_end,
      .i_periph_done, .i_bad_desc_ptr, .i_bad_buf_ptr, .i_full_wrong, .i_chan_abort_request, .i_flyby_read,
      .i_periph_eot, .i_desc_flags, .i_remaining_byte_count, .o_stall, .o_advance, .o_retry, .o_resume,
      .o_chan_irq, .o_irq);

   always #5 i_clock = ~i_clock;

   task automatic wrap_up();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Hang guard, far beyond the 133 or so cycles needed
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         wrap_up();
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr    <= 1'b0;
   endtask

   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      @(posedge i_clock);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd   <= 1'b0;
      #1 chk("read_data", e, o_rdata);
   endtask

   // Set enables, fire one event on channel 0 (k 7 adds an abort request in the stall), check flags, clear, check command
   task automatic scen(input int k, input logic [4:0] en, a, p, b);
      logic [31:0] w;
      w = {5'h1F, 2'b00, en, i_desc_flags[3:0], 16'h0000};
      wr(STATUS_BASE, w);
      @(posedge i_clock);
      case (k)
         0, 7: i_bad_desc_ptr[0] <= 1'b1;
         1: i_bad_buf_ptr[0] <= 1'b1;
         2: i_full_wrong[0] <= 1'b1;
         3: i_chan_abort_request[0] <= 1'b1;
         4: i_periph_eot[0] <= 1'b1;
         5: i_periph_done[0] <= 1'b1;
         default: i_desc_end[0] <= 1'b1;
      endcase
      @(posedge i_clock);
      {i_desc_end, i_periph_done, i_bad_desc_ptr, i_bad_buf_ptr, i_full_wrong, i_periph_eot} <= '0;
      // Only channel 0 ever has a pending flag, so the summary line follows it
      #1 chk("after_event", {26'h0, a, a[0]},
             {26'h0, o_stall[0], o_advance[0], o_retry[0], o_resume[0], o_chan_irq[0], o_irq});
      if (k == 7) begin
         @(posedge i_clock);
         i_chan_abort_request[0] <= 1'b1;
      end
      rd(STATUS_BASE, {p, w[26:0]});
      // Request dropped before the flag is cleared, so the next descriptor runs
      @(posedge i_clock);
      i_chan_abort_request[0] <= 1'b0;
      wr(STATUS_BASE, w);
      @(posedge i_clock);
      #1 chk("after_clear", {26'h0, b, b[0]},
             {26'h0, o_stall[0], o_advance[0], o_retry[0], o_resume[0], o_chan_irq[0], o_irq});
   endtask

   // Main sequence
   initial begin
      repeat (10) @(posedge i_clock);
      i_arst_n <= 1'b1;
      rd(STATUS_BASE, 32'h0);
      rd(STATUS_BASE + 15 * CHAN_STRIDE, 32'h000A1234);
      wr(STATUS_BASE + 15 * CHAN_STRIDE, 32'hFFFFFFFF);
      rd(STATUS_BASE + 15 * CHAN_STRIDE, 32'h01FA1234);
      rd(STATUS_BASE + 32'h4, 32'h0);
      scen(0, 5'h1F, 5'b10001, 5'b01000, 5'b00010);
      scen(1, 5'h1F, 5'b10001, 5'b01000, 5'b00010);
      scen(0, 5'h1B, 5'b10000, 5'b01000, 5'b00010);
      scen(2, 5'h02, 5'b10001, 5'b00100, 5'b00100);
      scen(3, 5'h01, 5'b10001, 5'b00010, 5'b01000);
      scen(7, 5'h1F, 5'b10001, 5'b01010, 5'b01000);
      scen(4, 5'h10, 5'b01001, 5'b10001, 5'b00000);
      scen(5, 5'h1F, 5'b01001, 5'b10000, 5'b00000);
      scen(6, 5'h08, 5'b01001, 5'b10000, 5'b00000);
      scen(6, 5'h00, 5'b01000, 5'b00000, 5'b00000);
      // Let the new flag settle before the next scenario builds its word
      @(posedge i_clock);
      i_desc_flags[2] <= 1'b1;
      @(posedge i_clock);
      scen(6, 5'h00, 5'b01000, 5'b10000, 5'b00000);
      wrap_up();
   end
endmodule
